// >>> logic/umcs_params.svh
`ifndef UMCS_PARAMS_SVH
`define UMCS_PARAMS_SVH

// modem control bit positions
`define UMCS_MCTL_DTR_BIT 0
`define UMCS_MCTL_RTS_BIT 1
`define UMCS_MCTL_LOOP_BIT 4
// interrupt enable bit for modem status events
`define UMCS_IER_MSI_BIT 3
// modem status bit positions
`define UMCS_MSTAT_DCTS_BIT 0
`define UMCS_MSTAT_TERI_BIT 2
`define UMCS_MSTAT_CTS_BIT 4
`define UMCS_MSTAT_RI_BIT 6

// reset values
`define UMCS_MCTL_RESET 8'h00
`define UMCS_IER_RESET 8'h00
`define UMCS_MSTAT_RESET 8'h00
`define UMCS_PIN_IDLE 1'b1

// index port address bytes chosen by the straps
`define UMCS_ADDR_LOW_0 8'h2E
`define UMCS_ADDR_LOW_1 8'h4E
`define UMCS_ADDR_HIGH_0 8'h00
`define UMCS_ADDR_HIGH_1 8'h16

// pin input synchroniser depth
`define UMCS_SYNC_STAGES 3

`endif

// >>> logic/umcs_pkg.sv
package umcs_pkg;

  typedef enum logic [0:0] {
    UMCS_STRAP_WAIT = 1'b0,
    UMCS_STRAP_DONE = 1'b1
  } umcs_strap_state_t;

  typedef struct packed {
    logic base_high_select;
    logic base_low_select;
  } umcs_straps_t;

endpackage : umcs_pkg

// >>> logic/umcs_pin_bus_if.sv
`timescale 1ns/1ps
interface umcs_pin_bus_if #(parameter int WIDTH = 4);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] clean;
  logic settled;

  modport sync_side(input raw, output clean, output settled);
  modport user_side(output raw, input clean, input settled);
endinterface : umcs_pin_bus_if

// >>> logic/umcs_pin_sync.sv
`timescale 1ns/1ps
`include "umcs_params.svh"
module umcs_pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk,
  input wire logic reset,
  umcs_pin_bus_if.sync_side pins
);

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("umcs_pin_sync needs at least one pin");
    end
  endgenerate

  // stages carry no reset so they track the pins while reset is held
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] clean_reg;
  logic settled_reg;
  wire [WIDTH-1:0] agree = ~(stage2_reg ^ stage3_reg);

  always_ff @(posedge clk) begin
    stage1_reg <= pins.raw;
    stage2_reg <= stage1_reg;
    stage3_reg <= stage2_reg;
  end

  // a level counts only once the second and third stages agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          clean_reg[i] <= `UMCS_PIN_IDLE;
        end else if (agree[i]) begin
          clean_reg[i] <= stage3_reg[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      settled_reg <= 1'b0;
    end else if (&agree) begin
      settled_reg <= 1'b1;
    end
  end

  assign pins.clean = clean_reg;
  assign pins.settled = settled_reg;

endmodule : umcs_pin_sync

// >>> logic/umcs_modem_ctrl.sv
// How it works
// - modem control bit 1 drives request_to_send_n low unless loop bit 4 is set
// - modem control bit 0 drives terminal_ready_n low unless loop bit 4 is set
// - reset leaves both handshake outputs high
// - request_to_send_n strap picks low byte 2E/4E
// - terminal_ready_n strap picks high byte 00/16
// - status bit 4 shows inverted clear_to_send_n
// - status bit 0 flags clear_to_send_n rising
// - enabled interrupt on any cts or ring change
// - clear_to_send_n never stalls the transmitter
// - status bit 6 shows inverted ring_indicator_n
// - status bit 2 flags ring_indicator_n rising
`timescale 1ns/1ps
`include "umcs_params.svh"
module umcs_modem_ctrl (
  input wire logic clk,
  input wire logic reset,
  input wire logic modem_control_wr,
  input wire logic [7:0] modem_control_wdata,
  output logic [7:0] modem_control_reg,
  input wire logic interrupt_enable_wr,
  input wire logic [7:0] interrupt_enable_wdata,
  output logic [7:0] interrupt_enable_reg,
  input wire logic modem_status_rd,
  output logic [7:0] modem_status_reg,
  output logic serial_port_irq,
  input wire logic serial_tx_bit,
  output logic serial_tx_out,
  input wire logic request_to_send_n_in,
  output logic request_to_send_n_out,
  output logic request_to_send_n_oe_n,
  input wire logic terminal_ready_n_in,
  output logic terminal_ready_n_out,
  output logic terminal_ready_n_oe_n,
  input wire logic clear_to_send_n,
  input wire logic ring_indicator_n,
  output logic base_low_select,
  output logic base_high_select,
  output logic [15:0] index_port_addr,
  output logic straps_valid
);

  localparam int PIN_CTS = 0;
  localparam int PIN_RI = 1;
  localparam int PIN_RTS = 2;
  localparam int PIN_DTR = 3;

  umcs_pin_bus_if #(.WIDTH(4)) pin_bus ();

  assign pin_bus.raw = {terminal_ready_n_in, request_to_send_n_in,
                        ring_indicator_n, clear_to_send_n};

  umcs_pin_sync #(.WIDTH(4)) u_pin_sync (
    .clk(clk),
    .reset(reset),
    .pins(pin_bus)
  );

  wire cts_n_clean = pin_bus.clean[PIN_CTS];
  wire ri_n_clean = pin_bus.clean[PIN_RI];
  wire inputs_settled = pin_bus.settled;

  // strap capture after reset release
  umcs_pkg::umcs_strap_state_t strap_state_reg;
  umcs_pkg::umcs_strap_state_t strap_state_next;
  umcs_pkg::umcs_straps_t straps_reg;
  umcs_pkg::umcs_straps_t straps_next;

  // pins stay released until the straps are read, so the board resistors set them
  always_comb begin
    strap_state_next = strap_state_reg;
    straps_next = straps_reg;
    unique case (strap_state_reg)
      umcs_pkg::UMCS_STRAP_WAIT: begin
        if (inputs_settled) begin
          straps_next.base_low_select = pin_bus.clean[PIN_RTS];
          straps_next.base_high_select = pin_bus.clean[PIN_DTR];
          strap_state_next = umcs_pkg::UMCS_STRAP_DONE;
        end
      end
      umcs_pkg::UMCS_STRAP_DONE: begin
        strap_state_next = umcs_pkg::UMCS_STRAP_DONE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strap_state_reg <= umcs_pkg::UMCS_STRAP_WAIT;
      straps_reg <= '0;
    end else begin
      strap_state_reg <= strap_state_next;
      straps_reg <= straps_next;
    end
  end

  wire strap_done = (strap_state_reg == umcs_pkg::UMCS_STRAP_DONE);

  assign base_low_select = straps_reg.base_low_select;
  assign base_high_select = straps_reg.base_high_select;
  assign straps_valid = strap_done;
  assign index_port_addr = {
    straps_reg.base_high_select ? `UMCS_ADDR_HIGH_1 : `UMCS_ADDR_HIGH_0,
    straps_reg.base_low_select ? `UMCS_ADDR_LOW_1 : `UMCS_ADDR_LOW_0
  };

  // control registers
  logic [7:0] mctl_next;
  logic [7:0] ier_next;
  assign mctl_next = modem_control_wr ? modem_control_wdata : modem_control_reg;
  assign ier_next = interrupt_enable_wr ? interrupt_enable_wdata : interrupt_enable_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      modem_control_reg <= `UMCS_MCTL_RESET;
      interrupt_enable_reg <= `UMCS_IER_RESET;
    end else begin
      modem_control_reg <= mctl_next;
      interrupt_enable_reg <= ier_next;
    end
  end

  // one decode serves both handshake pins
  function automatic logic drive_level_n(input logic ctrl_bit, input logic loop_on);
    drive_level_n = ~(ctrl_bit & ~loop_on);
  endfunction : drive_level_n

  // handshake outputs
  wire loop_mode = modem_control_reg[`UMCS_MCTL_LOOP_BIT];
  wire rts_n_next = drive_level_n(modem_control_reg[`UMCS_MCTL_RTS_BIT], loop_mode);
  wire dtr_n_next = drive_level_n(modem_control_reg[`UMCS_MCTL_DTR_BIT], loop_mode);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      request_to_send_n_out <= `UMCS_PIN_IDLE;
      terminal_ready_n_out <= `UMCS_PIN_IDLE;
      request_to_send_n_oe_n <= 1'b1;
      terminal_ready_n_oe_n <= 1'b1;
    end else begin
      request_to_send_n_out <= strap_done ? rts_n_next : `UMCS_PIN_IDLE;
      terminal_ready_n_out <= strap_done ? dtr_n_next : `UMCS_PIN_IDLE;
      request_to_send_n_oe_n <= ~strap_done;
      terminal_ready_n_oe_n <= ~strap_done;
    end
  end

  // transmit path has no term from clear_to_send_n on purpose
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      serial_tx_out <= `UMCS_PIN_IDLE;
    end else begin
      serial_tx_out <= serial_tx_bit;
    end
  end

  // modem status
  logic cts_n_prev_reg;
  logic ri_n_prev_reg;
  logic change_pending_reg;

  // strap_done rises one edge after settled, so the first settled levels reach
  // the previous-level flops before any edge is judged: no false change after reset
  wire cts_rise = strap_done & cts_n_clean & ~cts_n_prev_reg;
  wire ri_rise = strap_done & ri_n_clean & ~ri_n_prev_reg;
  wire any_change = strap_done &
                    ((cts_n_clean ^ cts_n_prev_reg) | (ri_n_clean ^ ri_n_prev_reg));

  logic [7:0] mstat_next;
  logic change_pending_next;

  // a new edge in the read cycle survives the clear
  always_comb begin
    mstat_next = `UMCS_MSTAT_RESET;
    mstat_next[`UMCS_MSTAT_CTS_BIT] = ~cts_n_clean;
    mstat_next[`UMCS_MSTAT_RI_BIT] = ~ri_n_clean;
    mstat_next[`UMCS_MSTAT_DCTS_BIT] = cts_rise |
      (modem_status_reg[`UMCS_MSTAT_DCTS_BIT] & ~modem_status_rd);
    mstat_next[`UMCS_MSTAT_TERI_BIT] = ri_rise |
      (modem_status_reg[`UMCS_MSTAT_TERI_BIT] & ~modem_status_rd);
    change_pending_next = any_change | (change_pending_reg & ~modem_status_rd);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cts_n_prev_reg <= `UMCS_PIN_IDLE;
      ri_n_prev_reg <= `UMCS_PIN_IDLE;
      modem_status_reg <= `UMCS_MSTAT_RESET;
      change_pending_reg <= 1'b0;
      serial_port_irq <= 1'b0;
    end else begin
      cts_n_prev_reg <= cts_n_clean;
      ri_n_prev_reg <= ri_n_clean;
      modem_status_reg <= mstat_next;
      change_pending_reg <= change_pending_next;
      serial_port_irq <= ier_next[`UMCS_IER_MSI_BIT] & change_pending_next;
    end
  end

endmodule : umcs_modem_ctrl

// >>> tb/umcs_line_model.sv
`timescale 1ns/1ps
module umcs_line_model (
  input wire logic strap_rts,
  input wire logic strap_dtr,
  input wire logic rts_out,
  input wire logic rts_oe_n,
  input wire logic dtr_out,
  input wire logic dtr_oe_n,
  input wire logic cts_assert,
  input wire logic ri_assert,
  output logic rts_pin,
  output logic dtr_pin,
  output logic clear_to_send_n,
  output logic ring_indicator_n
);
  // board resistors set the level only while the port leaves the pin released
  assign rts_pin = rts_oe_n ? strap_rts : rts_out;
  assign dtr_pin = dtr_oe_n ? strap_dtr : dtr_out;
  assign clear_to_send_n = !cts_assert;
  assign ring_indicator_n = !ri_assert;
endmodule : umcs_line_model

// >>> tb/umcs_checker.sv
`timescale 1ns/1ps
module umcs_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] modem_control_reg,
  input wire logic [7:0] interrupt_enable_reg,
  input wire logic modem_status_rd,
  input wire logic [7:0] modem_status_reg,
  input wire logic serial_port_irq,
  input wire logic serial_tx_bit,
  input wire logic serial_tx_out,
  input wire logic request_to_send_n_out,
  input wire logic terminal_ready_n_out,
  input wire logic clear_to_send_n,
  input wire logic ring_indicator_n,
  input wire logic straps_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_rts_drive: assert property (straps_valid && $past(straps_valid) |->
    request_to_send_n_out == !($past(modem_control_reg[1]) && !$past(modem_control_reg[4])))
    else $error("rts output wrong");
  a_dtr_drive: assert property (straps_valid && $past(straps_valid) |->
    terminal_ready_n_out == !($past(modem_control_reg[0]) && !$past(modem_control_reg[4])))
    else $error("dtr output wrong");
  a_idle_high: assert property (!straps_valid |->
    request_to_send_n_out && terminal_ready_n_out) else $error("outputs not idle");
  a_cts_level: assert property ((straps_valid && $stable(clear_to_send_n))[*6] |->
    modem_status_reg[4] == !clear_to_send_n) else $error("cts level bit wrong");
  a_ri_level: assert property ((straps_valid && $stable(ring_indicator_n))[*6] |->
    modem_status_reg[6] == !ring_indicator_n) else $error("ring level bit wrong");
  a_cts_delta: assert property (straps_valid && $rose(clear_to_send_n) |->
    ##[3:6] modem_status_reg[0]) else $error("cts delta not set");
  a_ri_trail: assert property (straps_valid && $rose(ring_indicator_n) |->
    ##[3:6] modem_status_reg[2]) else $error("ring delta not set");
  a_irq_raise: assert property (straps_valid && interrupt_enable_reg[3] &&
    ($changed(clear_to_send_n) || $changed(ring_indicator_n)) |-> ##[3:6] serial_port_irq)
    else $error("irq not raised");
  a_read_clears: assert property (
    ($stable(clear_to_send_n) && $stable(ring_indicator_n))[*6] ##0 modem_status_rd |=>
    !modem_status_reg[0] && !modem_status_reg[2] && !serial_port_irq)
    else $error("read did not clear flags");
  a_tx_ungated: assert property (!$past(reset) |->
    serial_tx_out == $past(serial_tx_bit)) else $error("tx path gated");
endmodule : umcs_checker

bind umcs_modem_ctrl umcs_checker chk (.*);

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic mc_wr = 1'b0;
  logic ie_wr = 1'b0;
  logic ms_rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic tx_bit = 1'b1;
  logic st_rts = 1'b0;
  logic st_dtr = 1'b0;
  logic cts_a = 1'b0;
  logic ri_a = 1'b0;
  logic rts_pin, dtr_pin, rts_out, rts_oe_n, dtr_out, dtr_oe_n, cts_n, ri_n;
  logic irq, tx_out, b_low, b_high, s_valid;
  logic [7:0] mctl, ier, mstat;
  logic [15:0] addr;
  int n_mismatch = 0;
  int check_count = 0;
  always #2.5 clk = ~clk;
  umcs_modem_ctrl dut (.clk(clk), .reset(reset), .modem_control_wr(mc_wr),
    .modem_control_wdata(wdata), .modem_control_reg(mctl), .interrupt_enable_wr(ie_wr),
    .interrupt_enable_wdata(wdata), .interrupt_enable_reg(ier), .modem_status_rd(ms_rd),
    .modem_status_reg(mstat), .serial_port_irq(irq), .serial_tx_bit(tx_bit),
    .serial_tx_out(tx_out), .request_to_send_n_in(rts_pin), .request_to_send_n_out(rts_out),
    .request_to_send_n_oe_n(rts_oe_n), .terminal_ready_n_in(dtr_pin),
    .terminal_ready_n_out(dtr_out), .terminal_ready_n_oe_n(dtr_oe_n),
    .clear_to_send_n(cts_n), .ring_indicator_n(ri_n), .base_low_select(b_low),
    .base_high_select(b_high), .index_port_addr(addr), .straps_valid(s_valid));
  umcs_line_model line (.strap_rts(st_rts), .strap_dtr(st_dtr), .rts_out(rts_out),
    .rts_oe_n(rts_oe_n), .dtr_out(dtr_out), .dtr_oe_n(dtr_oe_n), .cts_assert(cts_a),
    .ri_assert(ri_a), .rts_pin(rts_pin), .dtr_pin(dtr_pin), .clear_to_send_n(cts_n),
    .ring_indicator_n(ri_n));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask : chk
  task automatic wr(input logic sel, input logic [7:0] d);
    @(posedge clk);
    #1;
    mc_wr = !sel;
    ie_wr = sel;
    wdata = d;
    @(posedge clk);
    #1;
    mc_wr = 1'b0;
    ie_wr = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : wr
  task automatic rd();
    @(posedge clk);
    #1;
    ms_rd = 1'b1;
    @(posedge clk);
    #1;
    ms_rd = 1'b0;
  endtask : rd
  // pins need 5 edges to reach status; 8 leaves margin
  task automatic pin(input int i, input logic v);
    if (i)
      ri_a = v;
    else
      cts_a = v;
    repeat (8) @(posedge clk);
    #1;
  endtask : pin
  task automatic do_reset(input logic [1:0] s);
    st_rts = s[0];
    st_dtr = s[1];
    reset = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk("pins in reset", 16'h0003, {14'h0, rts_out, dtr_out});
    reset = 1'b0;
    for (int n = 0; n < 20 && s_valid !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk("valid", 16'h0001, {15'h0, s_valid});
    chk("straps", {14'h0, s}, {14'h0, b_high, b_low});
    chk("addr", {s[1] ? 8'h16 : 8'h00, s[0] ? 8'h4E : 8'h2E}, addr);
    @(posedge clk);
    #1;
    chk("drive", 16'h0, {14'h0, rts_oe_n, dtr_oe_n});
  endtask : do_reset
  initial begin
    #100000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    do_reset(2'h0);
    for (int v = 0; v < 8; v++) begin
      wr(1'b0, {3'h0, v[2], 2'h0, v[1:0]});
      chk("mctl", {11'h0, v[2], 2'h0, v[1:0]}, {8'h0, mctl});
      chk("rts", {15'h0, !(v[1] && !v[2])}, {15'h0, rts_out});
      chk("dtr", {15'h0, !(v[0] && !v[2])}, {15'h0, dtr_out});
    end
    wr(1'b1, 8'h08);
    chk("ier", 16'h0008, {8'h0, ier});
    for (int i = 0; i < 2; i++) begin
      rd();
      pin(i, 1'b1);
      chk("status", 16'h1 << (i ? 6 : 4), {8'h0, mstat});
      chk("irq", 16'h1, {15'h0, irq});
      rd();
      chk("status", 16'h1 << (i ? 6 : 4), {8'h0, mstat});
      chk("irq", 16'h0, {15'h0, irq});
      pin(i, 1'b0);
      chk("status", 16'h1 << (i ? 2 : 0), {8'h0, mstat});
      chk("irq", 16'h1, {15'h0, irq});
      rd();
    end
    wr(1'b1, 8'h00);
    chk("ier", 16'h0000, {8'h0, ier});
    pin(0, 1'b1);
    pin(1, 1'b1);
    chk("irq", 16'h0, {15'h0, irq});
    // cts settles before each bit, so a gated path would show
    for (int b = 0; b < 4; b++) begin
      pin(0, b[1]);
      tx_bit = b[0];
      @(posedge clk);
      #1;
      chk("tx", {15'h0, b[0]}, {15'h0, tx_out});
    end
    for (int k = 3; k >= 0; k--)
      do_reset(k[1:0]);
    // pins held asserted through reset must leave no change pending
    wr(1'b1, 8'h08);
    chk("status", 16'h0050, {8'h0, mstat});
    chk("irq", 16'h0, {15'h0, irq});
    give_verdict();
  end
endmodule : tb_top
